// ### rtl/stm_pkg.sv
// Purpose: Shared constants and types for the sixteen-bit mode timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Register offsets are byte indices on the plain register port.
package stm_pkg;
   localparam logic [3:0] OFF_CTL     = 4'h0;
   localparam logic [3:0] OFF_CNT_HI  = 4'h1;
   localparam logic [3:0] OFF_CNT_LO  = 4'h2;
   localparam logic [3:0] OFF_RLD_HI  = 4'h3;
   localparam logic [3:0] OFF_RLD_LO  = 4'h4;
   localparam logic [3:0] OFF_IRQ_ST  = 4'h5;
   localparam logic [3:0] OFF_IRQ_MSK = 4'h6;
   localparam logic [3:0] OFF_PINCFG  = 4'h7;
   localparam int CTL_EN_BIT  = 7;
   localparam int CTL_POL_BIT = 6;
   localparam int CTL_PRE_LSB = 3;
   localparam int CTL_MODE_LSB = 0;
   localparam int PIN_OUT_BIT = 0;
   localparam int PIN_IN_BIT  = 1;
   localparam int IRQ_RLD_BIT = 0;
   localparam int IRQ_CAP_BIT = 1;
   localparam logic [7:0]  CTL_RST   = 8'h00;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] RLD_RST   = 16'hFFFF;
   localparam logic [15:0] CNT_RELOAD = 16'h0001;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [6:0]  PRE_ONE   = 7'h01;

   typedef enum logic [2:0] {
      STM_ONE_SHOT   = 3'h0,
      STM_CONTINUOUS = 3'h1,
      STM_CAPTURE    = 3'h2,
      STM_COMPARE    = 3'h3,
      STM_DUAL_PWM   = 3'h4
   } stm_mode_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } stm_bus_t;
endpackage

// ### rtl/stm_timer.sv
// Purpose: Sixteen-bit up-counting timer with one-shot, continuous and
//          capture/compare modes, reload toggle output and coherent reads.
// Assumes: Pin input synchronous to clk; byte register port.
// Notes:   Prescale factor is 2^ctl[5:3].
// Contract
// (R1) Software loads the output polarity bit with the start level, then flips it after starting.
// (R2) Software disables, configures, loads start and reload, then enables, in that order.
// (R3) One-shot counting always uses the system clock whatever the pin setting.
// (R4) One-shot time-out is (reload minus start) times the prescale in clock periods.
// (R5) Continuous counting runs from the system clock up to the 16-bit reload value.
// (R6) On a continuous match the timer interrupts, loads 0001H and keeps counting.
// (R7) Continuous counting takes the system clock through the prescaler.
// (R8) Capture/compare starts on the first qualifying pin edge, which gives no interrupt.
// (R9) A capture holds (capture minus start) times prescale as elapsed clocks.
// (R10) Count reads while enabled never disturb the timer.
// (R11) An enabled high-byte read latches the low byte for the next low-byte read.
// (R12) A disabled low-byte read returns the live counter.
// (R13) With the output function on, the output pin toggles at each reload.
// (R14) The shared pin is timer input in all modes but dual complementary output.
// (R15) One-shot match interrupts, reloads and clears the enable.
// (R16) The prescaler advances the counter once per prescale terminal count.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module stm_timer (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire stm_pkg::stm_bus_t bus,
   output logic [7:0]        rdata,
   input  wire logic         tin,
   output logic              tout,
   output logic              tout_n,
   output logic              tout_n_oe,
   output logic              irq
);
   logic [7:0]  ctl_q;
   logic [15:0] cnt_q;
   logic [15:0] rld_q;
   logic [7:0]  hold_q;
   logic [6:0]  pre_q;
   logic [1:0]  ist_q;
   logic [1:0]  imsk_q;
   logic [1:0]  pin_q;
   logic        started_q;
   logic        tin_q;
   logic        tout_q;
   logic [7:0]  rdata_q;

   wire stm_pkg::stm_mode_t mode =
      stm_pkg::stm_mode_t'(ctl_q[stm_pkg::CTL_MODE_LSB +: 3]);
   wire       en       = ctl_q[stm_pkg::CTL_EN_BIT];
   wire       pol      = ctl_q[stm_pkg::CTL_POL_BIT];
   wire [2:0] pre_sel  = ctl_q[stm_pkg::CTL_PRE_LSB +: 3];
   wire [6:0] pre_last = 7'((8'h01 << pre_sel) - 8'h01);
   wire       out_fn   = pin_q[stm_pkg::PIN_OUT_BIT];
   wire       wr_ctl   = bus.wr && bus.addr == stm_pkg::OFF_CTL;
   wire       wr_chi   = bus.wr && bus.addr == stm_pkg::OFF_CNT_HI;
   wire       wr_clo   = bus.wr && bus.addr == stm_pkg::OFF_CNT_LO;
   wire       rd_chi   = bus.rd && bus.addr == stm_pkg::OFF_CNT_HI;
   wire       rd_clo   = bus.rd && bus.addr == stm_pkg::OFF_CNT_LO;
   wire       cc_mode  = mode == stm_pkg::STM_CAPTURE ||
                         mode == stm_pkg::STM_COMPARE;
   // Dual output mode frees the shared pin for the complement
   wire       in_sel   = pin_q[stm_pkg::PIN_IN_BIT] &&
                         mode != stm_pkg::STM_DUAL_PWM; // R14
   wire       tin_rise = in_sel && tin && !tin_q;
   // One-shot and continuous ignore the pin entirely
   wire       start_ev = en && cc_mode && !started_q && tin_rise; // R8
   // Start edge already counts, so a capture spans start to capture
   wire       gated    = cc_mode && !started_q && !start_ev; // R3 R7
   // At or past the last step, so a prescale change cannot stall
   wire       tick     = en && !gated && pre_q >= pre_last; // R16
   wire       match    = tick && cnt_inc == rld_q; // R4 R5
   wire       wr_rhi   = bus.wr && bus.addr == stm_pkg::OFF_RLD_HI;
   wire       wr_rlo   = bus.wr && bus.addr == stm_pkg::OFF_RLD_LO;
   wire       cap_ev   = en && cc_mode && started_q && tin_rise;
   wire [15:0] cnt_inc = 16'(cnt_q + 16'h0001);

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= stm_pkg::CTL_RST;
      end else if (wr_ctl) begin
         ctl_q <= bus.wdata;
      end else if (match && mode == stm_pkg::STM_ONE_SHOT) begin
         ctl_q[stm_pkg::CTL_EN_BIT] <= 1'b0; // R15
      end
   end

   // Held at zero while stopped so the first period is whole
   always_ff @(posedge clk) begin
      if (rst || !en || gated) begin
         pre_q <= 7'h00;
      end else if (tick) begin
         pre_q <= 7'h00; // R16
      end else begin
         pre_q <= 7'(pre_q + 7'h01);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= stm_pkg::CNT_RST;
      end else if (wr_chi) begin
         cnt_q[15:8] <= bus.wdata;
      end else if (wr_clo) begin
         cnt_q[7:0] <= bus.wdata;
      end else if (match) begin
         cnt_q <= stm_pkg::CNT_RELOAD; // R6 R15
      end else if (tick) begin
         cnt_q <= cnt_inc; // R4 R9
      end
   end

   // Capture stores the count in the reload pair; counting goes on
   always_ff @(posedge clk) begin
      if (rst) begin
         rld_q <= stm_pkg::RLD_RST;
      end else if (wr_rhi) begin
         rld_q[15:8] <= bus.wdata;
      end else if (wr_rlo) begin
         rld_q[7:0] <= bus.wdata;
      end else if (cap_ev && mode == stm_pkg::STM_CAPTURE) begin
         rld_q <= cnt_q; // R9
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         started_q <= 1'b0;
      end else if (!en) begin
         started_q <= 1'b0;
      end else if (cc_mode && tin_rise) begin
         started_q <= 1'b1; // R8
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tin_q <= 1'b0;
      end else begin
         tin_q <= tin;
      end
   end

   // Holding register only; counting path never sees reads
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= stm_pkg::BYTE_RST;
      end else if (rd_chi && en) begin
         hold_q <= cnt_q[7:0]; // R11 R10
      end
   end

   // Output follows polarity while idle, toggles on reload
   always_ff @(posedge clk) begin
      if (rst) begin
         tout_q <= 1'b0;
      end else if (!en) begin
         tout_q <= pol; // R1
      end else if (match && out_fn) begin
         tout_q <= !tout_q; // R13
      end
   end

   // First start edge is excluded since cap_ev needs started_q
   wire [1:0] ev = {cap_ev, match}; // R6 R8
   always_ff @(posedge clk) begin
      if (rst) begin
         ist_q <= 2'b00;
         imsk_q <= 2'b00;
         pin_q <= 2'b00;
      end else begin
         ist_q <= ev | (ist_q & ~((bus.wr &&
                  bus.addr == stm_pkg::OFF_IRQ_ST) ? bus.wdata[1:0] : 2'b00));
         if (bus.wr && bus.addr == stm_pkg::OFF_IRQ_MSK) begin
            imsk_q <= bus.wdata[1:0];
         end
         if (bus.wr && bus.addr == stm_pkg::OFF_PINCFG) begin
            pin_q <= bus.wdata[1:0];
         end
      end
   end

   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      case (bus.addr)
         stm_pkg::OFF_CTL:     rmux = ctl_q;
         stm_pkg::OFF_CNT_HI:  rmux = cnt_q[15:8];
         stm_pkg::OFF_CNT_LO:  rmux = en ? hold_q : cnt_q[7:0]; // R11 R12
         stm_pkg::OFF_RLD_HI:  rmux = rld_q[15:8];
         stm_pkg::OFF_RLD_LO:  rmux = rld_q[7:0];
         stm_pkg::OFF_IRQ_ST:  rmux = {6'h00, ist_q};
         stm_pkg::OFF_IRQ_MSK: rmux = {6'h00, imsk_q};
         stm_pkg::OFF_PINCFG:  rmux = {6'h00, pin_q};
         default:              rmux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         rdata_q <= rmux;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata     = rdata_q;
   assign tout      = out_fn ? tout_q : 1'b0;
   assign tout_n    = !tout_q;
   assign tout_n_oe = out_fn && mode == stm_pkg::STM_DUAL_PWM; // R14
   assign irq       = |(ist_q & imsk_q);

   a_oneshot_stop: assert property (@(posedge clk) disable iff (rst)
      match && mode == stm_pkg::STM_ONE_SHOT && !wr_ctl |=> !en)
      else $error("one-shot did not stop"); // R15
   a_cont_reload: assert property (@(posedge clk) disable iff (rst)
      match && mode == stm_pkg::STM_CONTINUOUS && !wr_chi && !wr_clo
      |=> cnt_q == 16'h0001 && ist_q[0] && en)
      else $error("continuous reload wrong"); // R6
   a_read_quiet: assert property (@(posedge clk) disable iff (rst)
      en && !wr_chi && !wr_clo && !match && !tick && !cap_ev
      |=> $stable(cnt_q))
      else $error("count moved without tick"); // R10
   a_hold_copy: assert property (@(posedge clk) disable iff (rst)
      rd_chi && en ##1 rd_clo && en |=> rdata == $past(cnt_q[7:0], 2))
      else $error("held low byte wrong"); // R11
   a_live_low: assert property (@(posedge clk) disable iff (rst)
      rd_clo && !en |=> rdata == $past(cnt_q[7:0]))
      else $error("disabled low read not live"); // R12
   a_out_toggle: assert property (@(posedge clk) disable iff (rst)
      match && out_fn && !wr_ctl |=> tout_q != $past(tout_q))
      else $error("output did not toggle"); // R13
   a_cc_wait: assert property (@(posedge clk) disable iff (rst)
      en && cc_mode && !started_q && !start_ev |-> !tick)
      else $error("counted before start edge"); // R8
   a_pre_step: assert property (@(posedge clk) disable iff (rst)
      tick && !match && !wr_chi && !wr_clo && !cap_ev
      |=> cnt_q == $past(cnt_inc))
      else $error("counter step wrong"); // R4

   // Check-only record of where a one-shot run began
   logic [15:0] os_start_q;
   logic [23:0] os_len_q;
   wire  [23:0] os_want =
      24'((24'(rld_q) - 24'(os_start_q)) << pre_sel);
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         os_start_q <= cnt_q;
         os_len_q   <= 24'h000000;
      end else begin
         os_len_q <= 24'(os_len_q + 24'h000001);
      end
   end

   a_os_length: assert property (@(posedge clk) disable iff (rst) // R4
      match && mode == stm_pkg::STM_ONE_SHOT
      |-> 24'(os_len_q + 24'h000001) == os_want)
      else $error("one-shot length wrong");

   a_os_free_run: assert property (@(posedge clk) disable iff (rst) // R3
      en && mode == stm_pkg::STM_ONE_SHOT && !tick && !wr_ctl
      |=> pre_q == 7'($past(pre_q) + 7'h01))
      else $error("one-shot prescaler stalled");

   a_cont_free_run: assert property (@(posedge clk) disable iff (rst) // R7
      en && mode == stm_pkg::STM_CONTINUOUS && !tick && !wr_ctl
      |=> pre_q == 7'($past(pre_q) + 7'h01))
      else $error("continuous prescaler stalled");

   a_tick_clear: assert property (@(posedge clk) disable iff (rst) // R16
      tick
      |=> pre_q == 7'h00)
      else $error("prescaler not restarted");

   a_pre_bound: assert property (@(posedge clk) disable iff (rst) // R16
      en && !gated && !wr_ctl
      |=> pre_q <= pre_last)
      else $error("prescaler overran");

   a_rld_flag: assert property (@(posedge clk) disable iff (rst) // R6
      match
      |=> ist_q[stm_pkg::IRQ_RLD_BIT])
      else $error("reload status not set");

   a_os_reload: assert property (@(posedge clk) disable iff (rst) // R15
      match && mode == stm_pkg::STM_ONE_SHOT && !wr_chi && !wr_clo
      |=> cnt_q == stm_pkg::CNT_RELOAD)
      else $error("one-shot count not reloaded");

   a_cont_runs: assert property (@(posedge clk) disable iff (rst) // R6
      match && mode == stm_pkg::STM_CONTINUOUS && !wr_ctl
      |=> en)
      else $error("continuous run stopped");

   a_irq_level: assert property (@(posedge clk) disable iff (rst) // R6
      (ist_q & imsk_q) != 2'b00
      |-> irq)
      else $error("interrupt not raised");

   a_gated_hold: assert property (@(posedge clk) disable iff (rst) // R8
      en && gated && !wr_chi && !wr_clo
      |=> $stable(cnt_q))
      else $error("count moved before start");

   a_first_quiet: assert property (@(posedge clk) disable iff (rst) // R8
      start_ev && !ist_q[stm_pkg::IRQ_CAP_BIT]
      |=> !ist_q[stm_pkg::IRQ_CAP_BIT])
      else $error("start edge raised status");

   a_start_latch: assert property (@(posedge clk) disable iff (rst) // R8
      start_ev && !wr_ctl
      |=> started_q)
      else $error("start edge not taken");

   a_cap_store: assert property (@(posedge clk) disable iff (rst) // R9
      cap_ev && mode == stm_pkg::STM_CAPTURE && !wr_rhi && !wr_rlo
      |=> rld_q == $past(cnt_q))
      else $error("capture value wrong");

   a_cap_flag: assert property (@(posedge clk) disable iff (rst) // R9
      cap_ev
      |=> ist_q[stm_pkg::IRQ_CAP_BIT])
      else $error("capture status not set");

   a_rd_no_disturb: assert property (@(posedge clk) disable iff (rst) // R10
      bus.rd && !bus.wr && !match && !cap_ev
      |=> $stable(ctl_q) && $stable(rld_q))
      else $error("read disturbed timer");

   a_hold_only_rd: assert property (@(posedge clk) disable iff (rst) // R11
      !(rd_chi && en)
      |=> $stable(hold_q))
      else $error("held byte changed");

   a_hi_live: assert property (@(posedge clk) disable iff (rst) // R11
      rd_chi
      |=> rdata == $past(cnt_q[15:8]))
      else $error("high byte read wrong");

   a_out_hold: assert property (@(posedge clk) disable iff (rst) // R13
      en && !match
      |=> $stable(tout_q))
      else $error("output moved without reload");

   a_pin_off: assert property (@(posedge clk) disable iff (rst) // R13
      !out_fn
      |-> !tout)
      else $error("output driven while off");

   a_oe_dual: assert property (@(posedge clk) disable iff (rst) // R14
      tout_n_oe
      |-> mode == stm_pkg::STM_DUAL_PWM)
      else $error("complement driven outside dual");

   a_dual_no_in: assert property (@(posedge clk) disable iff (rst) // R14
      mode == stm_pkg::STM_DUAL_PWM
      |-> !tin_rise)
      else $error("input seen in dual mode");
endmodule

// ### testbench/tb_top.sv
// Purpose: Register-level bench for the sixteen-bit mode timer.
// Assumes: Design latency of one cycle from match to irq.
// Notes:   Cycle figures are exact; every range check has equal low and high bounds.
`timescale 1ns/1ps
module tb_top;
   logic              clk;
   logic              rst;
   stm_pkg::stm_bus_t bus;
   logic [7:0]        rdata;
   logic              tin;
   logic              tout;
   logic              tout_n;
   logic              tout_n_oe;
   logic              irq;
   logic [7:0]        b;
   logic [15:0]       v1;
   logic [15:0]       v2;
   int                mismatches;
   int                num_checks;
   int                cyc;
   int                n;
   int                m;

   stm_timer dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .tin(tin), .tout(tout), .tout_n(tout_n), .tout_n_oe(tout_n_oe),
      .irq(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         mismatches++;
         $display("ERROR timeout expected 0 seen 1");
         results();
      end
   end

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // High then low byte with no gap; the held copy needs only that order
   task rd_pair(output logic [15:0] v);
      @(posedge clk);
      bus.addr <= 4'h1;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.addr <= 4'h2;
      #1 v[15:8] = rdata;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 v[7:0] = rdata;
   endtask

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task chk_rng(input string nm, input int lo, input int hi, input int g);
      num_checks++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task tick;
      @(posedge clk);
      #1;
   endtask

   // Edges until irq rises, or until tout changes level
   task wait_ev(input bit on_tout, output int k);
      logic t0;
      t0 = tout;
      k = 0;
      while (k < 2000 && (on_tout ? tout === t0 : irq !== 1'b1)) begin
         tick();
         k++;
      end
   endtask

   initial begin
      rst = 1'b1;
      bus = '0;
      tin = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      tick();
      chk("irq", 1'b0, irq);
      chk("tout", 1'b0, tout);
      chk("tout_n", 1'b1, tout_n);
      chk("tout_n_oe", 1'b0, tout_n_oe);
      rd(4'h3, b); chk("rld_hi", 8'hFF, b);
      rd(4'h4, b); chk("rld_lo", 8'hFF, b);
      wr(4'hF, 8'h55);
      rd(4'hF, b); chk("unmapped", 8'h00, b);
      $display("test reset done");
      // One-shot, pin set as input but idle: clock still counts
      wr(4'h0, 8'h08);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h04);
      wr(4'h6, 8'h01);
      wr(4'h7, 8'h03);
      wr(4'h0, 8'h88);
      wr(4'h0, 8'hC8);
      wait_ev(1'b0, n);
      // Eight cycles from enable, two already spent on the flip
      chk_rng("oneshot_cycles", 6, 6, n);
      rd(4'h0, b); chk("ctl_en", 1'b0, b[7]);
      chk("tout_toggle", 1'b1, tout);
      rd(4'h1, b); chk("cnt_hi", 8'h00, b);
      rd(4'h2, b); chk("cnt_lo", 8'h01, b);
      wr(4'h5, 8'h01);
      tick();
      chk("irq_clear", 1'b0, irq);
      $display("test one-shot done");
      // Continuous, prescale 4, reads mid-period must not shift it
      wr(4'h0, 8'h11);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h4, 8'h10);
      wr(4'h0, 8'h91);
      wait_ev(1'b1, n);
      for (m = 0; m < 4; m++) rd(4'h1 + m[3:0], b);
      wait_ev(1'b1, n);
      chk_rng("cont_period", 60, 60, n + 8);
      wr(4'h0, 8'h11);
      rd(4'h5, b); chk("st_reload", 1'b1, b[0]);
      wr(4'h6, 8'h00);
      tick();
      chk("irq_masked", 1'b0, irq);
      wr(4'h6, 8'h01);
      tick();
      chk("irq_unmasked", 1'b1, irq);
      wr(4'h5, 8'h01);
      tick();
      chk("irq_w1c", 1'b0, irq);
      $display("test continuous done");
      // Live low byte when stopped, held low byte when running
      wr(4'h1, 8'h12);
      wr(4'h2, 8'h34);
      rd(4'h2, b); chk("live_lo", 8'h34, b);
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'hFF);
      wr(4'h0, 8'h81);
      rd(4'h1, b);
      v1[15:8] = b;
      repeat (20) @(posedge clk);
      rd(4'h2, b);
      v1[7:0] = b;
      rd_pair(v2);
      chk_rng("coherent", 24, 24, int'(v2 - v1));
      wr(4'h0, 8'h01);
      $display("test coherent read done");
      // Capture: idle until first edge, which sets no status
      wr(4'h7, 8'h02);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h5, 8'h03);
      wr(4'h0, 8'h82);
      repeat (10) @(posedge clk);
      rd(4'h1, b); chk("cap_idle_hi", 8'h00, b);
      rd(4'h2, b); chk("cap_idle_lo", 8'h00, b);
      @(posedge clk);
      tin <= 1'b1;
      repeat (5) @(posedge clk);
      tin <= 1'b0;
      rd(4'h5, b); chk("first_edge_st", 8'h00, b);
      repeat (21) @(posedge clk);
      tin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(4'h5, b); chk("cap_st", 1'b1, b[1]);
      rd(4'h3, b);
      v1[15:8] = b;
      rd(4'h4, b);
      v1[7:0] = b;
      chk_rng("cap_value", 28, 28, int'(v1));
      wr(4'h0, 8'h02);
      tin <= 1'b0;
      wr(4'h7, 8'h03);
      wr(4'h0, 8'h84);
      tick();
      chk("dual_oe", 1'b1, tout_n_oe);
      wr(4'h0, 8'h04);
      $display("test capture and dual done");
      results();
   end
endmodule
